// *** hdl/dsd_supervisor.sv ***
// Supervisory, protection and watchdog logic of the stepper driver
`timescale 1ns/10ps
module dsd_supervisor #(
	parameter int MS_CYCLES   = dsd_pkg::MS_CYCLES,
	parameter int POR_HOLD_MS = dsd_pkg::POR_HOLD_MS,
	parameter int WD_MIN_MS   = dsd_pkg::WD_MIN_WINDOW_MS,
	parameter int AMP_W       = 5,
	parameter int ADC_W       = 10
) (
	// Clock, reset, enable
	input  wire logic             clock_in,
	input  wire logic             resetn_in,
	input  wire logic             ce_in,
	// Pins from outside the clock domain
	input  wire logic             hard_clear_input_in,
	input  wire logic             chip_select_n_in,
	// Control bits written over the serial port
	input  wire logic [AMP_W-1:0] peak_amplitude_setting_in,
	input  wire logic             load_angle_transparent_bit_in,
	input  wire logic             load_angle_gain_bit_in,
	input  wire logic             watchdog_enable_bit_in,
	input  wire logic             watchdog_enable_write_in,
	input  wire logic [3:0]       watchdog_timeout_select_in,
	input  wire logic             sleep_bit_in,
	input  wire logic             status_read_in,
	input  wire logic [1:0]       status_read_sel_in,
	// Analog monitors
	input  wire logic             temp_warn_in,
	input  wire logic             temp_shutdown_in,
	input  wire logic [5:0]       overcurrent_in,
	input  wire logic [1:0]       full_duty_in,
	input  wire logic             pump_low_in,
	input  wire logic             pwm_period_start_in,
	input  wire logic [1:0]       coil_zero_cross_in,
	input  wire logic             pwm_sample_hold_in,
	input  wire logic [ADC_W-1:0] coil_voltage_in,
	// Status flags
	output logic                  thermal_warning_flag_out,
	output logic                  thermal_shutdown_flag_out,
	output logic [2:0]            overcurrent_flags_x_out,
	output logic [2:0]            overcurrent_flags_y_out,
	output logic                  open_coil_flag_x_out,
	output logic                  open_coil_flag_y_out,
	output logic                  pump_fail_flag_out,
	output logic                  watchdog_boot_flag_out,
	// Pins and driver control
	output logic                  error_out_n_out,
	output logic                  reset_out_n_out,
	output logic                  reset_out_n_oe_out,
	output logic [1:0]            driver_enable_out,
	output logic [AMP_W-1:0]      applied_amplitude_out,
	output logic [ADC_W-1:0]      load_angle_output_out
);
	localparam int CLR_CYC  = dsd_pkg::CLR_MIN_CYCLES;
	localparam int WD_PULSE = dsd_pkg::WD_PULSE_MS;

	logic [1:0] pin_sync;
	wire        clr_pin = pin_sync[0];
	wire        cs_high = pin_sync[1];

	dsd_sync #(.WIDTH(2)) u_sync (
		.clock_in  (clock_in),
		.resetn_in (resetn_in),
		.ce_in     (ce_in),
		.async_in  ({chip_select_n_in, hard_clear_input_in}),
		.sync_out  (pin_sync)
	);

	// Hard clear qualified by minimum hold time, ignored in sleep
	logic [dsd_pkg::CLR_CNT_W-1:0] clr_cnt_reg;
	wire clr_long = clr_cnt_reg >= dsd_pkg::CLR_CNT_W'(CLR_CYC);
	wire hard_clr = clr_pin && clr_long && !sleep_bit_in;
	wire soft_rst = hard_clr;

	always_ff @(posedge clock_in) begin
		if (!resetn_in)
			clr_cnt_reg <= '0;
		else if (ce_in)
			clr_cnt_reg <= !clr_pin ? '0 : clr_long ? clr_cnt_reg : clr_cnt_reg + 1'b1;
	end

	// Millisecond tick; frozen in sleep so the watchdog holds its value
	logic [16:0] ms_div_reg;
	wire         ms_tick = (ms_div_reg == 17'(MS_CYCLES - 1));
	wire         run = ce_in && !sleep_bit_in;

	always_ff @(posedge clock_in) begin
		if (!resetn_in || soft_rst)
			ms_div_reg <= '0;
		else if (run)
			ms_div_reg <= ms_tick ? '0 : ms_div_reg + 17'h00001;
	end

	// Peak amplitude applied on PWM period boundary only
	always_ff @(posedge clock_in) begin
		if (!resetn_in || soft_rst)
			applied_amplitude_out <= dsd_pkg::AMP_RESET;
		else if (ce_in && pwm_period_start_in)
			applied_amplitude_out <= peak_amplitude_setting_in;
	end

	// Load angle sampling: hold at the end of any coil zero crossing
	logic [1:0]       zc_prev_reg;
	logic [ADC_W-1:0] held_reg;
	wire  [1:0]       zc_end = zc_prev_reg & ~coil_zero_cross_in;
	wire              take = (|zc_end) || ((|coil_zero_cross_in) && pwm_sample_hold_in);
	wire  [ADC_W-1:0] scaled = load_angle_gain_bit_in ? (coil_voltage_in >> 2)
	                                                  : (coil_voltage_in >> 1);
	wire  [ADC_W-1:0] sla_next = load_angle_transparent_bit_in ? scaled : held_reg;

	always_ff @(posedge clock_in) begin
		if (!resetn_in || soft_rst) begin
			zc_prev_reg           <= '0;
			held_reg              <= '0;
			load_angle_output_out <= '0;
		end else if (ce_in) begin
			zc_prev_reg <= coil_zero_cross_in;
			if (take)
				held_reg <= scaled;
			load_angle_output_out <= sla_next;
		end
	end

	// Open coil timers
	logic [1:0] open_exp;
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_open
			dsd_open_timer u_open (
				.clock_in     (clock_in),
				.resetn_in    (resetn_in),
				.ce_in        (run),
				.clear_in     (soft_rst),
				.ms_tick_in   (ms_tick),
				.full_duty_in (full_duty_in[gi]),
				.expired_out  (open_exp[gi])
			);
		end
	endgenerate

	// Status flags: hardware set wins over read clear
	wire upd = ce_in && cs_high;
	wire rd0 = status_read_in && status_read_sel_in == 2'h0;
	wire rd1 = status_read_in && status_read_sel_in == 2'h1;
	wire rd2 = status_read_in && status_read_sel_in == 2'h2;
	wire rd3 = status_read_in && status_read_sel_in == 2'h3;
	wire tsd_clear = rd2 && !temp_warn_in;
	logic tsd_read_reg;
	logic [5:0] ovc_next;
	assign ovc_next = overcurrent_in
		| ({overcurrent_flags_y_out, overcurrent_flags_x_out}
		   & ~({{3{rd2}}, {3{rd1}}}));

	always_ff @(posedge clock_in) begin
		if (!resetn_in || soft_rst) begin
			thermal_warning_flag_out  <= 1'b0;
			thermal_shutdown_flag_out <= 1'b0;
			tsd_read_reg              <= 1'b0;
			overcurrent_flags_x_out   <= dsd_pkg::OVC_RESET[2:0];
			overcurrent_flags_y_out   <= dsd_pkg::OVC_RESET[5:3];
			open_coil_flag_x_out      <= 1'b0;
			open_coil_flag_y_out      <= 1'b0;
			pump_fail_flag_out        <= 1'b1;
		end else if (upd) begin
			thermal_warning_flag_out <= temp_warn_in | (thermal_warning_flag_out & ~rd0);
			if (temp_shutdown_in)
				thermal_shutdown_flag_out <= 1'b1;
			else if ((tsd_clear || tsd_read_reg) && !temp_warn_in)
				thermal_shutdown_flag_out <= 1'b0;
			tsd_read_reg <= !temp_shutdown_in && (tsd_read_reg || rd2) && temp_warn_in;
			overcurrent_flags_x_out <= ovc_next[2:0];
			overcurrent_flags_y_out <= ovc_next[5:3];
			open_coil_flag_x_out <= open_exp[0] | (open_coil_flag_x_out & ~rd3);
			open_coil_flag_y_out <= open_exp[1] | (open_coil_flag_y_out & ~rd3);
			pump_fail_flag_out   <= pump_low_in | (pump_fail_flag_out & ~rd3);
		end
	end

	wire any_err = thermal_warning_flag_out | thermal_shutdown_flag_out
		| (|overcurrent_flags_x_out) | (|overcurrent_flags_y_out)
		| open_coil_flag_x_out | open_coil_flag_y_out | pump_fail_flag_out;

	always_ff @(posedge clock_in) begin
		if (!resetn_in)
			error_out_n_out <= 1'b1;
		else if (upd)
			error_out_n_out <= !any_err;
	end

	// Drivers: float on shutdown, overcurrent, sleep; a set open coil flag disables its coil only,
	// and the flag stays latched until a status read with select 3, so the coil stays
	// disabled after full duty ends until that read
	wire any_ovc = (|overcurrent_flags_x_out) | (|overcurrent_flags_y_out);
	wire drv_all = !thermal_shutdown_flag_out && !any_ovc && !sleep_bit_in;
	always_ff @(posedge clock_in) begin
		if (!resetn_in)
			driver_enable_out <= 2'h0;
		else if (ce_in)
			driver_enable_out <= {2{drv_all}} & ~{open_coil_flag_y_out, open_coil_flag_x_out};
	end

	// Watchdog and reset output
	dsd_pkg::dsd_rst_state_t st_reg;
	logic [9:0] wd_ms_reg;
	logic [9:0] hold_ms_reg;
	logic       wd_armed_reg;
	wire  [9:0] wd_limit = 10'(dsd_pkg::WD_STEP_MS) * ({6'h00, watchdog_timeout_select_in} + 10'h001);
	wire        wd_kick  = watchdog_enable_write_in && watchdog_enable_bit_in;
	wire        wd_early = wd_armed_reg && wd_kick && (wd_ms_reg < 10'(WD_MIN_MS));
	wire        wd_late  = wd_armed_reg && (wd_ms_reg >= wd_limit);
	wire        wd_fire  = st_reg == dsd_pkg::DSD_RST_IDLE && (wd_early || wd_late);

	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			st_reg                 <= dsd_pkg::DSD_RST_POR;
			hold_ms_reg            <= '0;
			reset_out_n_out        <= 1'b0;
			reset_out_n_oe_out     <= 1'b1;
			watchdog_boot_flag_out <= 1'b0;
		end else if (ce_in) begin
			unique case (st_reg)
				dsd_pkg::DSD_RST_POR: begin
					if (ms_tick)
						hold_ms_reg <= hold_ms_reg + 10'h001;
					if (hold_ms_reg >= 10'(POR_HOLD_MS)) begin
						st_reg             <= dsd_pkg::DSD_RST_IDLE;
						reset_out_n_out    <= 1'b1;
						reset_out_n_oe_out <= 1'b0;
					end
				end
				dsd_pkg::DSD_RST_IDLE: begin
					hold_ms_reg <= '0;
					if (wd_fire && !soft_rst) begin
						st_reg                 <= dsd_pkg::DSD_RST_WDPULSE;
						reset_out_n_out        <= 1'b0;
						reset_out_n_oe_out     <= 1'b1;
						watchdog_boot_flag_out <= 1'b1;
					end
				end
				dsd_pkg::DSD_RST_WDPULSE: begin
					if (ms_tick)
						hold_ms_reg <= hold_ms_reg + 10'h001;
					if (hold_ms_reg >= 10'(WD_PULSE)) begin
						st_reg             <= dsd_pkg::DSD_RST_IDLE;
						reset_out_n_out    <= 1'b1;
						reset_out_n_oe_out <= 1'b0;
					end
				end
				// Unused state code: back to idle without driving the reset pin
				default: st_reg <= dsd_pkg::DSD_RST_IDLE;
			endcase
			if (soft_rst)
				watchdog_boot_flag_out <= 1'b0;
		end
	end

	// Counter freezes in sleep, cleared by hard clear or a kick
	always_ff @(posedge clock_in) begin
		if (!resetn_in || soft_rst) begin
			wd_ms_reg    <= '0;
			wd_armed_reg <= 1'b0;
		end else if (ce_in) begin
			if (wd_kick || wd_fire || st_reg != dsd_pkg::DSD_RST_IDLE)
				wd_ms_reg <= '0;
			else if (run && ms_tick && wd_armed_reg && wd_ms_reg != 10'h3FF)
				wd_ms_reg <= wd_ms_reg + 10'h001;
			if (wd_fire)
				wd_armed_reg <= 1'b0;
			else if (wd_kick)
				wd_armed_reg <= 1'b1;
		end
	end

	a_err_follows: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(ce_in && cs_high && any_err) |=> !error_out_n_out)
		else $error("error output not low with flag set");
	a_amp_hold: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(ce_in && !pwm_period_start_in && !soft_rst) |=> $stable(applied_amplitude_out))
		else $error("amplitude changed outside PWM period start");
	a_tsd_float: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(ce_in && thermal_shutdown_flag_out) |=> driver_enable_out == 2'h0)
		else $error("drivers enabled during shutdown");
	a_sleep_float: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(ce_in && sleep_bit_in) |=> driver_enable_out == 2'h0)
		else $error("drivers enabled in sleep");
	a_sleep_freeze: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(ce_in && sleep_bit_in && !soft_rst && !wd_kick && st_reg == dsd_pkg::DSD_RST_IDLE
		 && !wd_fire) |=> $stable(wd_ms_reg))
		else $error("watchdog counted in sleep");
	a_wd_pulse: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(ce_in && wd_fire && !soft_rst) |=> !reset_out_n_out && watchdog_boot_flag_out)
		else $error("watchdog fault without reset pulse");
	a_clr_no_rst: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(soft_rst && reset_out_n_out) |=> reset_out_n_out)
		else $error("hard clear asserted reset output");
	a_cs_freeze: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(!cs_high && !soft_rst) |=> $stable(pump_fail_flag_out) && $stable(thermal_warning_flag_out))
		else $error("flags changed with chip select low");
	a_sla_transp: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(ce_in && load_angle_transparent_bit_in && !soft_rst) |=> load_angle_output_out == $past(scaled))
		else $error("transparent load angle mismatch");
	a_ovc_float: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(ce_in && any_ovc) |=> driver_enable_out == 2'h0)
		else $error("drivers enabled with overcurrent latched");
	a_clr_boot: assert property (@(posedge clock_in) disable iff (!resetn_in)
		(ce_in && soft_rst) |=> !watchdog_boot_flag_out)
		else $error("boot flag kept through hard clear");
	a_clr_wdog: assert property (@(posedge clock_in) disable iff (!resetn_in)
		soft_rst |=> wd_ms_reg == 10'h000 && !wd_armed_reg)
		else $error("watchdog kept running through hard clear");

	c_wd_fire: cover property (@(posedge clock_in) disable iff (!resetn_in) wd_fire);
	c_open_x: cover property (@(posedge clock_in) disable iff (!resetn_in) $rose(open_coil_flag_x_out));
	c_hard_clr: cover property (@(posedge clock_in) disable iff (!resetn_in) soft_rst);
	c_tsd: cover property (@(posedge clock_in) disable iff (!resetn_in) $fell(thermal_shutdown_flag_out));
	c_sleep_armed: cover property (@(posedge clock_in) disable iff (!resetn_in) sleep_bit_in && wd_armed_reg);
endmodule // dsd_supervisor

// *** hdl/dsd_pkg.sv ***
// Shared constants and types for the driver supervisor and diagnostics block
package dsd_pkg;

	localparam int CLK_FREQ_HZ        = 100_000_000;
	localparam int NS_PER_CLK         = 10;
	// Millisecond tick derived from the clock rate
	localparam int MS_CYCLES          = CLK_FREQ_HZ / 1000;
	localparam int OPEN_TIMEOUT_MS    = 200;
	localparam int WD_STEP_MS         = 32;
	localparam int WD_MIN_WINDOW_MS   = 4;
	localparam int POR_HOLD_MS        = 10;
	localparam int WD_PULSE_MS        = 1;
	localparam int CLR_MIN_NS         = 100;
	localparam int CLR_MIN_CYCLES     = (CLR_MIN_NS + NS_PER_CLK - 1) / NS_PER_CLK;
	localparam int CLR_CNT_W          = 4;
	localparam int MS_CNT_W           = 10;
	localparam logic [4:0] AMP_RESET  = 5'h00;
	localparam logic [3:0] WDT_RESET  = 4'h0;
	localparam logic [5:0] OVC_RESET  = 6'h00;

	typedef enum logic [1:0] {
		DSD_RST_POR,
		DSD_RST_IDLE,
		DSD_RST_WDPULSE
	} dsd_rst_state_t;

endpackage

// *** hdl/dsd_sync.sv ***
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/10ps
module dsd_sync #(
	parameter int WIDTH = 1
) (
	// Clock and control
	input  wire logic             clock_in,
	input  wire logic             resetn_in,
	input  wire logic             ce_in,
	// Data
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] s1_reg;
	logic [WIDTH-1:0] s2_reg;
	logic [WIDTH-1:0] s3_reg;
	// Value only moves once the two settled stages agree
	wire  [WIDTH-1:0] agree = ~(s2_reg ^ s3_reg);
	wire  [WIDTH-1:0] sync_next = (agree & s2_reg) | (~agree & sync_out);

	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			s1_reg   <= '0;
			s2_reg   <= '0;
			s3_reg   <= '0;
			sync_out <= '0;
		end else if (ce_in) begin
			s1_reg   <= async_in;
			s2_reg   <= s1_reg;
			s3_reg   <= s2_reg;
			sync_out <= sync_next;
		end
	end
endmodule // dsd_sync

// *** hdl/dsd_open_timer.sv ***
// Per-coil full duty timer that flags a coil stuck at 100 percent duty
`timescale 1ns/10ps
module dsd_open_timer #(
	parameter int TIMEOUT_MS = dsd_pkg::OPEN_TIMEOUT_MS
) (
	// Clock and control
	input  wire logic clock_in,
	input  wire logic resetn_in,
	input  wire logic ce_in,
	input  wire logic clear_in,
	input  wire logic ms_tick_in,
	// Coil status
	input  wire logic full_duty_in,
	output logic      expired_out
);
	logic [8:0] ms_cnt_reg;
	wire        over = ms_cnt_reg > 9'(TIMEOUT_MS);

	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			ms_cnt_reg  <= '0;
			expired_out <= 1'b0;
		end else if (ce_in) begin
			if (clear_in || !full_duty_in)
				ms_cnt_reg <= '0;
			else if (ms_tick_in && !over)
				ms_cnt_reg <= ms_cnt_reg + 9'h001;
			expired_out <= over && full_duty_in && !clear_in;
		end
	end
endmodule // dsd_open_timer

// *** sim/dsd_host_model.sv ***
// Host microcontroller model: framed status reads and watchdog kicks
`timescale 1ns/10ps
module dsd_host_model (
	// Clock
	input  wire logic clock_in,
	// Serial port side
	output logic       chip_select_n_out,
	output logic       status_read_out,
	output logic [1:0] status_read_sel_out,
	output logic       watchdog_enable_bit_out,
	output logic       watchdog_enable_write_out
);
	// Frame length in cycles; the bench varies it for slow hosts
	int frame_len = 4;

	initial begin
		chip_select_n_out = 1'b1;
		status_read_out = 1'b0;
		status_read_sel_out = 2'h0;
		watchdog_enable_bit_out = 1'b0;
		watchdog_enable_write_out = 1'b0;
	end

	// Select goes back high after frame_len cycles and stays high 5 cycles, so the block may update its flags again
	task automatic frame();
		@(posedge clock_in);
		chip_select_n_out <= 1'b0;
		repeat (frame_len) @(posedge clock_in);
		chip_select_n_out <= 1'b1;
		repeat (5) @(posedge clock_in);
	endtask

	task automatic read_status(input logic [1:0] sel);
		frame();
		status_read_sel_out <= sel;
		status_read_out <= 1'b1;
		@(posedge clock_in);
		status_read_out <= 1'b0;
	endtask

	task automatic kick();
		frame();
		watchdog_enable_bit_out <= 1'b1;
		watchdog_enable_write_out <= 1'b1;
		@(posedge clock_in);
		watchdog_enable_write_out <= 1'b0;
	endtask
endmodule  // dsd_host_model

// *** sim/tb_driver_supervisor_diagnostics.sv ***
// Self-checking bench: flags, error pin, watchdog, hard clear and sleep
`timescale 1ns/10ps
module tb_driver_supervisor_diagnostics;
	localparam int MS = 10;
	logic       clock_in = 1'b0;
	logic       resetn_in = 1'b0;
	logic       hclr = 1'b0, load_angle_transparent_bit = 1'b0, load_angle_gain_bit = 1'b0, sleep = 1'b0;
	logic       ce = 1'b1;
	logic       twarn = 1'b0, thermal_shutdown_flag = 1'b0, plow = 1'b0, pstart = 1'b0, psh = 1'b1;
	logic [4:0] amp = 5'h00;
	logic [3:0] wdt = 4'h0;
	logic [5:0] ovc = 6'h00;
	logic [1:0] fduty = 2'h0, zc = 2'h0;
	logic [9:0] vcoil = 10'h000;
	logic       cs_n, rd, wd_bit, wd_wr, tw_f, tsd_f, ox_f, oy_f, pf_f, boot_f;
	logic       err_n, rst_n, rst_oe;
	logic [1:0] rd_sel, drv;
	logic [2:0] ovx, ovy;
	logic [4:0] amp_o;
	logic [9:0] la_o;
	int         n_errors = 0;
	int         comparisons = 0;
	logic [31:0] seed = 32'h1C6C;

	always #5 clock_in = ~clock_in;

	dsd_host_model host (.clock_in(clock_in), .chip_select_n_out(cs_n),
		.status_read_out(rd), .status_read_sel_out(rd_sel),
		.watchdog_enable_bit_out(wd_bit), .watchdog_enable_write_out(wd_wr));

	dsd_supervisor #(.MS_CYCLES(MS)) dut_u (.clock_in(clock_in), .resetn_in(resetn_in),
		.ce_in(ce), .hard_clear_input_in(hclr), .chip_select_n_in(cs_n),
		.peak_amplitude_setting_in(amp), .load_angle_transparent_bit_in(load_angle_transparent_bit),
		.load_angle_gain_bit_in(load_angle_gain_bit), .watchdog_enable_bit_in(wd_bit),
		.watchdog_enable_write_in(wd_wr), .watchdog_timeout_select_in(wdt),
		.sleep_bit_in(sleep), .status_read_in(rd), .status_read_sel_in(rd_sel),
		.temp_warn_in(twarn), .temp_shutdown_in(thermal_shutdown_flag), .overcurrent_in(ovc),
		.full_duty_in(fduty), .pump_low_in(plow), .pwm_period_start_in(pstart),
		.coil_zero_cross_in(zc), .pwm_sample_hold_in(psh), .coil_voltage_in(vcoil),
		.thermal_warning_flag_out(tw_f), .thermal_shutdown_flag_out(tsd_f),
		.overcurrent_flags_x_out(ovx), .overcurrent_flags_y_out(ovy),
		.open_coil_flag_x_out(ox_f), .open_coil_flag_y_out(oy_f),
		.pump_fail_flag_out(pf_f), .watchdog_boot_flag_out(boot_f),
		.error_out_n_out(err_n), .reset_out_n_out(rst_n), .reset_out_n_oe_out(rst_oe),
		.driver_enable_out(drv), .applied_amplitude_out(amp_o),
		.load_angle_output_out(la_o));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clock_in);
	endtask

	// Polls the reset pin so a one-millisecond pulse cannot slip between checks
	task automatic pulse_seen(input int n, input logic want);
		logic seen;
		seen = 1'b0;
		repeat (n) begin
			@(posedge clock_in);
			seen |= ~rst_n;
		end
		chk(seen, want);
	endtask

	task automatic complete_run();
		if (n_errors == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		cyc(100000);
		n_errors++;
		complete_run();
	end

	initial begin
		logic [9:0] v;
		logic [4:0] a;
		int t;
		cyc(16);
		chk({rst_n, rst_oe, pf_f, err_n, boot_f}, 5'h0E);
		resetn_in <= 1'b1;
		cyc(95);
		chk(rst_n, 1'b0);
		cyc(20);
		chk({rst_n, rst_oe}, 2'h2);
		host.read_status(2'h3);
		cyc(2);
		chk({pf_f, err_n}, 2'h1);
		plow <= 1'b1;
		cyc(3);
		chk({pf_f, err_n}, 2'h2);
		plow <= 1'b0;
		host.read_status(2'h3);
		host.frame_len = 2 + int'(rnd() % 12);
		for (int i = 0; i < 6; i++) begin
			ovc <= 6'h01 << i;
			cyc(3);
			chk({ovy, ovx, drv}, {6'h01 << i, 2'h0});
			chk(err_n, 1'b0);
			ovc <= 6'h00;
			host.read_status(i < 3 ? 2'h1 : 2'h2);
			cyc(2);
			chk({ovy, ovx, drv, err_n}, 9'h007);
		end
		twarn <= 1'b1;
		thermal_shutdown_flag <= 1'b1;
		cyc(3);
		chk({tw_f, tsd_f, drv}, 4'hC);
		thermal_shutdown_flag <= 1'b0;
		host.read_status(2'h2);
		cyc(2);
		chk(tsd_f, 1'b1);
		twarn <= 1'b0;
		host.read_status(2'h2);
		host.read_status(2'h0);
		cyc(2);
		chk({tw_f, tsd_f, err_n}, 3'h1);
		host.frame_len = 30;
		fork
			host.frame();
			begin
				cyc(6);
				ovc <= 6'h08;
				cyc(20);
				chk({ovy, err_n}, 4'h1);
			end
		join
		cyc(3);
		chk({ovy, err_n}, 4'h2);
		ovc <= 6'h00;
		host.frame_len = 4;
		host.read_status(2'h2);
		a = dsd_pkg::AMP_RESET;
		for (int i = 0; i < 3; i++) begin
			amp <= 5'(rnd());
			cyc(4);
			chk(amp_o, a);
			a = amp;
			pstart <= 1'b1;
			cyc(1);
			pstart <= 1'b0;
			cyc(2);
			chk(amp_o, a);
		end
		// Clock enable low: a period start must not load the new setting
		ce <= 1'b0;
		amp <= ~a;
		pstart <= 1'b1;
		cyc(3);
		chk(amp_o, a);
		ce <= 1'b1;
		pstart <= 1'b0;
		cyc(2);
		chk(amp_o, a);
		for (int g = 0; g < 2; g++) begin
			v = 10'(rnd());
			load_angle_transparent_bit <= 1'b1;
			load_angle_gain_bit <= g[0];
			psh <= g[0];
			vcoil <= v;
			cyc(4);
			chk(la_o, v >> (g + 1));
			zc <= 2'h1 << g;
			cyc(3);
			zc <= 2'h0;
			load_angle_transparent_bit <= 1'b0;
			cyc(1);
			vcoil <= ~v;
			cyc(4);
			chk(la_o, v >> (g + 1));
		end
		for (int k = 0; k < 2; k++) begin
			fduty <= 2'h1 << k;
			cyc(195 * MS);
			chk({oy_f, ox_f}, 2'h0);
			cyc(12 * MS);
			chk({oy_f, ox_f, drv, err_n}, {2'h1 << k, ~(2'h1 << k), 1'b0});
			fduty <= 2'h0;
			host.read_status(2'h3);
		end
		for (int s = 0; s < 16; s++) begin
			t = 32 * (s + 1);
			wdt <= 4'(s);
			host.kick();
			cyc((5 + int'(rnd() % 5)) * MS);
			host.kick();
			pulse_seen((t - 2) * MS, 1'b0);
			pulse_seen(5 * MS, 1'b1);
			chk(boot_f, 1'b1);
		end
		wdt <= 4'h0;
		host.kick();
		host.kick();
		pulse_seen(4 * MS, 1'b1);
		twarn <= 1'b1;
		host.kick();
		twarn <= 1'b0;
		cyc(20 * MS);
		sleep <= 1'b1;
		cyc(3);
		chk(drv, 2'h0);
		hclr <= 1'b1;
		cyc(20);
		hclr <= 1'b0;
		pulse_seen(50 * MS, 1'b0);
		chk(tw_f, 1'b1);
		// Host leaves sleep and steps only after pump start-up; no step pin here
		sleep <= 1'b0;
		pulse_seen(8 * MS, 1'b0);
		pulse_seen(7 * MS, 1'b1);
		host.kick();
		cyc(5 * MS);
		hclr <= 1'b1;
		pulse_seen(20, 1'b0);
		hclr <= 1'b0;
		cyc(6);
		chk({tw_f, boot_f, amp_o}, 7'h00);
		pulse_seen(40 * MS, 1'b0);
		complete_run();
	end
endmodule  // tb_driver_supervisor_diagnostics
